// ---- rtl/tjt_pkg.sv ----
// Shared constants and types of the test access port
package tjt_pkg;

    // Instruction register
    localparam int unsigned IR_LEN = 3;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPTURE = 3'h1;
    localparam logic [2:0] IR_RESET = 3'h1;

    // Identification register; value is arbitrary
    localparam int unsigned ID_LEN = 32;
    localparam logic [31:0] ID_CODE_DEFAULT = 32'h0000_0001;

    // Reset values
    localparam logic TDO_RESET = 1'b0;
    // Synchroniser reset per pin, msb first: clock low, pull-ups high, test reset low
    localparam logic [4:0] SYNC_RESET = 5'h0d;

    // Pin sampling
    localparam int unsigned PIN_COUNT = 5;

    typedef enum logic [3:0] {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAP_DR,
        TAP_SHIFT_DR,
        TAP_EXIT1_DR,
        TAP_PAUSE_DR,
        TAP_EXIT2_DR,
        TAP_UPD_DR,
        TAP_SEL_IR,
        TAP_CAP_IR,
        TAP_SHIFT_IR,
        TAP_EXIT1_IR,
        TAP_PAUSE_IR,
        TAP_EXIT2_IR,
        TAP_UPD_IR
    } tjt_tap_state_t;

    // Test pins as seen on the device side
    typedef struct packed {
        logic test_shift_clock;
        logic test_mode_select;
        logic test_serial_in;
        logic test_port_reset_n;
        logic digital_io_enable;
    } tjt_pins_t;

endpackage

// ---- rtl/tjt_sync.sv ----
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module tjt_sync #(
    parameter int unsigned      WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    // Data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            // Idle pin levels, so no false edge or float follows reset
            meta_q <= RESET_VALUE;
            sync_q <= RESET_VALUE;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule
`default_nettype wire

// ---- rtl/tjt_test_port.sv ----
// Boundary-scan test access port with digital I/O float control
`timescale 1ns/1ps
`default_nettype none
module tjt_test_port #(
    parameter logic [31:0] ID_CODE = tjt_pkg::ID_CODE_DEFAULT
) (
    // System clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_n_i,
    // Test pins
    input  wire tjt_pkg::tjt_pins_t pins_i,
    output logic                   test_serial_out_o,
    output logic                   test_serial_out_oe_o,
    // Device-wide status
    output logic                   io_float_o,
    output logic                   test_mode_o,
    output logic [2:0]             instruction_o,
    output tjt_pkg::tjt_tap_state_t tap_state_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and test-clock edges

    tjt_pkg::tjt_pins_t pins_s;
    logic               tck_prev_q;
    logic               trst_prev_q;
    logic               tck_rise;
    logic               tck_fall;
    logic               trst_rise;

    tjt_sync #(
        .WIDTH       (tjt_pkg::PIN_COUNT),
        .RESET_VALUE (tjt_pkg::SYNC_RESET)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .async_i   (pins_i),
        .sync_o    (pins_s)
    );

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            tck_prev_q  <= 1'b0;
            trst_prev_q <= 1'b0;
        end
        else
        begin
            tck_prev_q  <= pins_s.test_shift_clock;
            trst_prev_q <= pins_s.test_port_reset_n;
        end
    end

    assign tck_rise  = pins_s.test_shift_clock & ~tck_prev_q;
    assign tck_fall  = ~pins_s.test_shift_clock & tck_prev_q;
    assign trst_rise = pins_s.test_port_reset_n & ~trst_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // TAP controller

    tjt_pkg::tjt_tap_state_t state_q;
    tjt_pkg::tjt_tap_state_t state_d;
    logic                    tms;

    assign tms = pins_s.test_mode_select;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            tjt_pkg::TAP_RESET:    state_d = tms ? tjt_pkg::TAP_RESET    : tjt_pkg::TAP_IDLE;
            tjt_pkg::TAP_IDLE:     state_d = tms ? tjt_pkg::TAP_SEL_DR   : tjt_pkg::TAP_IDLE;
            tjt_pkg::TAP_SEL_DR:   state_d = tms ? tjt_pkg::TAP_SEL_IR   : tjt_pkg::TAP_CAP_DR;
            tjt_pkg::TAP_CAP_DR:   state_d = tms ? tjt_pkg::TAP_EXIT1_DR : tjt_pkg::TAP_SHIFT_DR;
            tjt_pkg::TAP_SHIFT_DR: state_d = tms ? tjt_pkg::TAP_EXIT1_DR : tjt_pkg::TAP_SHIFT_DR;
            tjt_pkg::TAP_EXIT1_DR: state_d = tms ? tjt_pkg::TAP_UPD_DR   : tjt_pkg::TAP_PAUSE_DR;
            tjt_pkg::TAP_PAUSE_DR: state_d = tms ? tjt_pkg::TAP_EXIT2_DR : tjt_pkg::TAP_PAUSE_DR;
            tjt_pkg::TAP_EXIT2_DR: state_d = tms ? tjt_pkg::TAP_UPD_DR   : tjt_pkg::TAP_SHIFT_DR;
            tjt_pkg::TAP_UPD_DR:   state_d = tms ? tjt_pkg::TAP_SEL_DR   : tjt_pkg::TAP_IDLE;
            tjt_pkg::TAP_SEL_IR:   state_d = tms ? tjt_pkg::TAP_RESET    : tjt_pkg::TAP_CAP_IR;
            tjt_pkg::TAP_CAP_IR:   state_d = tms ? tjt_pkg::TAP_EXIT1_IR : tjt_pkg::TAP_SHIFT_IR;
            tjt_pkg::TAP_SHIFT_IR: state_d = tms ? tjt_pkg::TAP_EXIT1_IR : tjt_pkg::TAP_SHIFT_IR;
            tjt_pkg::TAP_EXIT1_IR: state_d = tms ? tjt_pkg::TAP_UPD_IR   : tjt_pkg::TAP_PAUSE_IR;
            tjt_pkg::TAP_PAUSE_IR: state_d = tms ? tjt_pkg::TAP_EXIT2_IR : tjt_pkg::TAP_PAUSE_IR;
            tjt_pkg::TAP_EXIT2_IR: state_d = tms ? tjt_pkg::TAP_UPD_IR   : tjt_pkg::TAP_SHIFT_IR;
            tjt_pkg::TAP_UPD_IR:   state_d = tms ? tjt_pkg::TAP_SEL_DR   : tjt_pkg::TAP_IDLE;
            default:               state_d = tjt_pkg::TAP_RESET;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            state_q <= tjt_pkg::TAP_RESET;
        else if (!pins_s.test_port_reset_n)
            state_q <= tjt_pkg::TAP_RESET;
        else if (tck_rise)
            state_q <= state_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction register

    logic [2:0] ir_shift_q;
    logic [2:0] ir_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            ir_shift_q <= tjt_pkg::IR_RESET;
        else if (tck_rise && state_q == tjt_pkg::TAP_CAP_IR)
            ir_shift_q <= tjt_pkg::IR_CAPTURE;
        else if (tck_rise && state_q == tjt_pkg::TAP_SHIFT_IR)
            ir_shift_q <= {pins_s.test_serial_in, ir_shift_q[2:1]};
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            ir_q <= tjt_pkg::IR_RESET;
        else if (!pins_s.test_port_reset_n || state_q == tjt_pkg::TAP_RESET)
            ir_q <= tjt_pkg::IR_IDCODE;
        else if (tck_rise && state_q == tjt_pkg::TAP_UPD_IR)
            ir_q <= ir_shift_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Data registers: identification and bypass

    logic        sel_id;
    logic [31:0] id_shift_q;
    logic        bypass_q;

    assign sel_id = (ir_q == tjt_pkg::IR_IDCODE);

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            id_shift_q <= ID_CODE;
        else if (tck_rise && state_q == tjt_pkg::TAP_CAP_DR)
            id_shift_q <= ID_CODE;
        else if (tck_rise && state_q == tjt_pkg::TAP_SHIFT_DR && sel_id)
            id_shift_q <= {pins_s.test_serial_in, id_shift_q[31:1]};
    end

    // Anything but the identification code selects bypass
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            bypass_q <= 1'b0;
        else if (tck_rise && state_q == tjt_pkg::TAP_CAP_DR)
            bypass_q <= 1'b0;
        else if (tck_rise && state_q == tjt_pkg::TAP_SHIFT_DR && !sel_id)
            bypass_q <= pins_s.test_serial_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial output, changed on the falling test-clock edge; output enable also cleared while test reset is low

    logic shifting;
    logic tdo_bit;
    logic tdo_q;
    logic tdo_oe_q;

    assign shifting = (state_q == tjt_pkg::TAP_SHIFT_DR) || (state_q == tjt_pkg::TAP_SHIFT_IR);
    assign tdo_bit  = (state_q == tjt_pkg::TAP_SHIFT_IR) ? ir_shift_q[0] :
                      sel_id ? id_shift_q[0] : bypass_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            tdo_q    <= tjt_pkg::TDO_RESET;
            tdo_oe_q <= 1'b0;
        end
        else if (!pins_s.test_port_reset_n)
        begin
            tdo_oe_q <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_q    <= tdo_bit;
            tdo_oe_q <= shifting;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test mode and digital I/O float

    logic test_mode_q;
    logic io_float_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            test_mode_q <= 1'b0;
        else if (!pins_s.test_port_reset_n)
            test_mode_q <= 1'b0;
        else if (trst_rise)
            test_mode_q <= 1'b1;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            io_float_q <= 1'b0;
        else
            io_float_q <= ~pins_s.digital_io_enable & ~pins_s.test_port_reset_n;
    end

    assign test_serial_out_o    = tdo_q;
    assign test_serial_out_oe_o = tdo_oe_q;
    assign io_float_o           = io_float_q;
    assign test_mode_o          = test_mode_q;
    assign instruction_o        = ir_q;
    assign tap_state_o          = state_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_tap_step;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (tck_rise && pins_s.test_port_reset_n && state_q == tjt_pkg::TAP_IDLE && tms)
            |=> (state_q == tjt_pkg::TAP_SEL_DR);
    endproperty
    a_tap_step: assert property (p_tap_step) else $error("TAP did not step on mode select");

    property p_bypass_capture;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (tck_rise && state_q == tjt_pkg::TAP_SHIFT_DR && !sel_id)
            |=> (bypass_q == $past(pins_s.test_serial_in));
    endproperty
    a_bypass_capture: assert property (p_bypass_capture) else $error("Serial input not captured");

    property p_tdo_fall;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (tck_fall && pins_s.test_port_reset_n)
            |=> (tdo_oe_q == $past(shifting)) && (!$past(shifting) || tdo_q == $past(tdo_bit));
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("Serial output wrong after falling edge");

    property p_tdo_hold;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!tck_fall && pins_s.test_port_reset_n) |=> $stable(tdo_q);
    endproperty
    a_tdo_hold: assert property (p_tdo_hold) else $error("Serial output moved off the falling edge");

    property p_trst_reset;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !pins_s.test_port_reset_n |=> (state_q == tjt_pkg::TAP_RESET) && !tdo_oe_q;
    endproperty
    a_trst_reset: assert property (p_trst_reset) else $error("Test reset did not reset TAP");

    property p_id_mode;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        trst_rise |=> test_mode_q && (ir_q == tjt_pkg::IR_IDCODE);
    endproperty
    a_id_mode: assert property (p_id_mode) else $error("Identification mode not entered");

    property p_leave_test;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !pins_s.test_port_reset_n ##1 !pins_s.test_port_reset_n |-> !test_mode_q;
    endproperty
    a_leave_test: assert property (p_leave_test) else $error("Test mode kept under test reset");

    property p_io_float;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        ##1 (io_float_q == (!$past(pins_s.digital_io_enable) && !$past(pins_s.test_port_reset_n)));
    endproperty
    a_io_float: assert property (p_io_float) else $error("Digital I/O float state wrong");

    property p_ir_update;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (tck_rise && pins_s.test_port_reset_n && state_q == tjt_pkg::TAP_UPD_IR)
            |=> (ir_q == $past(ir_shift_q)) && (state_q != tjt_pkg::TAP_UPD_IR);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("Instruction not updated");

endmodule
`default_nettype wire

// ---- test/tjt_ctrl_model.sv ----
// Boundary-scan controller model driving the test pins
`timescale 1ns/1ps
`default_nettype none
module tjt_ctrl_model (
    // Clock
    input  wire logic              clk_sys_i,
    // Serial return line
    input  wire logic              tdo_i,
    input  wire logic              tdo_oe_i,
    // Test pins
    output var tjt_pkg::tjt_pins_t pins_o
);
    logic line_q = 1'b0;

    initial
    begin
        pins_o = 5'h0d;
    end

    // Floating line shows inverse of last driven level
    always @(posedge clk_sys_i)
        if (tdo_oe_i)
            line_q <= tdo_i;

    // One test-clock period, clock parked low afterwards
    task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
        pins_o.test_mode_select = tms;
        pins_o.test_serial_in   = tdi;
        repeat (4) @(posedge clk_sys_i);
        #1;
        oe  = tdo_oe_i;
        tdo = tdo_oe_i ? tdo_i : ~line_q;
        pins_o.test_shift_clock = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        pins_o.test_shift_clock = 1'b0;
    endtask

    task automatic walk(input logic [7:0] seq, input int n);
        logic t;
        logic e;
        for (int i = 0; i < n; i++)
            step(seq[i], 1'b1, t, e);
    endtask

    task automatic set_reset(input logic v);
        pins_o.test_port_reset_n = v;
    endtask

    task automatic set_enable(input logic v);
        pins_o.digital_io_enable = v;
    endtask
endmodule
`default_nettype wire

// ---- test/tb_tjt_test_port.sv ----
// Self-checking bench of the test access port
`timescale 1ns/1ps
`default_nettype none
module tb_tjt_test_port;
    localparam logic [31:0] ID_VALUE = 32'h5a3c_96e1; // Arbitrary value

    logic                    clk_sys_i = 1'b0;
    logic                    reset_n_i = 1'b0;
    tjt_pkg::tjt_pins_t      pins;
    logic                    tdo;
    logic                    tdo_oe;
    logic                    io_float;
    logic                    test_mode;
    logic [2:0]              instruction;
    tjt_pkg::tjt_tap_state_t tap_state;
    int                      n_mismatch = 0;
    int                      compares   = 0;
    int                      cycles     = 0;

    always #50 clk_sys_i = ~clk_sys_i;

    tjt_test_port #(.ID_CODE(ID_VALUE)) DUT (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .pins_i(pins),
        .test_serial_out_o(tdo), .test_serial_out_oe_o(tdo_oe), .io_float_o(io_float),
        .test_mode_o(test_mode), .instruction_o(instruction), .tap_state_o(tap_state)
    );

    tjt_ctrl_model u_ctrl (.clk_sys_i(clk_sys_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .pins_o(pins));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            $display("ERROR %0t: run did not finish", $time);
            stop_test();
        end
    end

    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk_vec(tap_state, tjt_pkg::TAP_RESET, "state");
        chk_vec({1'b0, instruction}, {1'b0, tjt_pkg::IR_RESET}, "ir");
        chk_bit(tdo_oe, 1'b0, "oe");
        chk_bit(test_mode, 1'b0, "mode");
        chk_bit(io_float, 1'b0, "float");
    endtask

    task automatic t_enter();
        u_ctrl.set_reset(1'b1);
        wait_cyc(2);
        chk_bit(test_mode, 1'b0, "mode early");
        wait_cyc(3);
        chk_bit(test_mode, 1'b1, "mode");
        u_ctrl.walk(8'h1f, 6);
        wait_cyc(1);
        chk_vec(tap_state, tjt_pkg::TAP_IDLE, "idle");
    endtask

    task automatic t_idcode();
        logic t;
        logic e;
        u_ctrl.walk(8'h01, 3);
        for (int i = 0; i < 32; i++)
        begin
            u_ctrl.step(i == 31, 1'b0, t, e);
            chk_bit(e, 1'b1, "oe shift");
            chk_bit(t, ID_VALUE[i], "id bit");
        end
        u_ctrl.step(1'b1, 1'b1, t, e);
        chk_bit(e, 1'b0, "oe exit");
        u_ctrl.walk(8'h00, 1);
    endtask

    task automatic ir_scan(input logic [2:0] code);
        logic t;
        logic e;
        u_ctrl.walk(8'h03, 4);
        for (int i = 0; i < 3; i++)
        begin
            u_ctrl.step(i == 2, code[i], t, e);
            chk_bit(t, tjt_pkg::IR_CAPTURE[i], "ir capture");
            chk_bit(e, 1'b1, "oe ir");
        end
        u_ctrl.walk(8'h01, 2);
        wait_cyc(4);
        chk_vec({1'b0, instruction}, {1'b0, code}, "ir update");
    endtask

    task automatic t_bypass();
        logic       t;
        logic       e;
        logic [3:0] pat;
        pat = 4'hd;
        u_ctrl.walk(8'h01, 3);
        for (int i = 0; i < 5; i++)
        begin
            u_ctrl.step(i == 4, (i < 4) ? pat[i] : 1'b0, t, e);
            chk_bit(t, (i == 0) ? 1'b0 : pat[i-1], "bypass");
        end
        u_ctrl.walk(8'h01, 2);
    endtask

    task automatic t_trst();
        u_ctrl.walk(8'h01, 3);
        wait_cyc(4);
        chk_bit(tdo_oe, 1'b1, "shift oe");
        u_ctrl.set_reset(1'b0);
        wait_cyc(4);
        chk_vec(tap_state, tjt_pkg::TAP_RESET, "trst state");
        chk_bit(tdo_oe, 1'b0, "trst oe");
        chk_bit(test_mode, 1'b0, "trst mode");
        chk_vec({1'b0, instruction}, {1'b0, tjt_pkg::IR_RESET}, "trst ir");
    endtask

    task automatic t_float();
        for (int k = 0; k < 4; k++)
        begin
            u_ctrl.set_enable(k[0]);
            u_ctrl.set_reset(k[1]);
            wait_cyc(4);
            chk_bit(io_float, ~k[0] & ~k[1], "float");
        end
        u_ctrl.set_reset(1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        #1;
        reset_n_i = 1'b1;
        wait_cyc(2);
        t_reset();
        t_enter();
        t_idcode();
        ir_scan(tjt_pkg::IR_EXTEST);
        ir_scan(tjt_pkg::IR_IDCODE);
        ir_scan(tjt_pkg::IR_BYPASS);
        t_bypass();
        t_trst();
        t_float();
        stop_test();
    end
endmodule
`default_nettype wire
